// [pkg/ubr_pkg.sv]
package ubr_pkg;

  // Register offsets inside the eight-byte window
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IRQ_EN = 3'h1;
  localparam logic [2:0] OFF_EVT = 3'h2;
  localparam logic [2:0] OFF_SEL = 3'h3;
  localparam logic [2:0] OFF_MODEM_CTL = 3'h4;
  localparam logic [2:0] OFF_LINK_STAT = 3'h5;
  localparam logic [2:0] OFF_MODEM_STAT = 3'h6;
  localparam logic [2:0] OFF_SCRATCH = 3'h7;
  localparam logic [2:0] OFF_DIV_LO = 3'h0;
  localparam logic [2:0] OFF_DIV_HI = 3'h1;
  localparam logic [2:0] OFF_EXT_ONE = 3'h2;
  localparam logic [2:0] OFF_EXT_TWO = 3'h4;
  localparam logic [2:0] OFF_TX_LVL = 3'h6;
  localparam logic [2:0] OFF_RX_LVL = 3'h7;
  localparam logic [2:0] OFF_REV = 3'h0;
  localparam logic [2:0] OFF_LC_COPY = 3'h1;
  localparam logic [2:0] OFF_FC_COPY = 3'h2;

  // Field positions
  localparam int SEL_BIT = 7;
  localparam int SEL_SUB_BIT = 6;
  localparam int FIFO_EN_BIT = 0;
  localparam int EXT_MODE_BIT = 0;

  // Select byte codes for the extended and infrared banks
  localparam logic [7:0] SEL_BANK2 = 8'hE0;
  localparam logic [7:0] SEL_BANK3 = 8'hE4;
  localparam logic [7:0] SEL_BANK4 = 8'hE8;
  localparam logic [7:0] SEL_BANK5 = 8'hEC;
  localparam logic [7:0] SEL_BANK6 = 8'hF0;
  localparam logic [7:0] SEL_BANK7 = 8'hF4;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;

  typedef enum logic [2:0] {
    BANK0 = 3'b000,
    BANK1 = 3'b001,
    BANK2 = 3'b010,
    BANK3 = 3'b011,
    BANK4 = 3'b100,
    BANK5 = 3'b101,
    BANK6 = 3'b110,
    BANK7 = 3'b111
  } ubr_bank_e;

  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b00,
    MODE_FIFO = 2'b01,
    MODE_EXT = 2'b10
  } ubr_mode_e;

  // Control bytes handed to the UART datapath
  typedef struct packed {
    logic [7:0] irq_enable;
    logic [7:0] line_control;
    logic [7:0] modem_ctl;
    logic [7:0] fifo_control;
    logic [15:0] divisor;
    logic [7:0] ext_one;
    logic [7:0] ext_two;
    logic [7:0] scratch;
  } ubr_ctrl_s;

  // Status bytes supplied by the UART datapath
  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] event_ident;
    logic [7:0] link_status;
    logic [7:0] modem_status;
    logic [7:0] tx_level;
    logic [7:0] rx_level;
  } ubr_stat_s;

endpackage

// [core/ubr_regmap.sv]
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Port runs plain, FIFO or extended UART
// - Eight banks of eight byte offsets; banks 4-7 hold only the select byte
// - Same offsets 0-7, bank picks register
// - Select byte at offset 3 everywhere
// - Top bit set: bank 1, or banks 2-7 for the exact codes E0 to F4
// - Select byte decodes to banks 0-7
// - Bank 0 offset 2: ident read, FIFO write
// - Bank 1: legacy divisor bytes, rest reserved
// - Bank 2: divisor, extended controls, levels
// - Bank 3 offset 1: line control copy
// - Bank 3: FIFO control copy, revision
module ubr_regmap
  import ubr_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h00 // Arbitrary value
)
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RDATA,
  input wire ubr_stat_s STAT,
  output ubr_ctrl_s CTRL,
  output logic [7:0] TX_DATA,
  output logic TX_LOAD,
  output logic RX_POP,
  output logic EVT_READ,
  output logic LINK_READ,
  output ubr_bank_e BANK,
  output ubr_mode_e MODE
);

  logic wr_en;
  logic rd_en;
  logic [7:0] sel_q;
  logic [7:0] line_control_q;
  ubr_bank_e bank_q;
  ubr_bank_e bank_d;
  logic [7:0] tx_data_q;
  logic tx_load_q;
  logic [7:0] fifo_control_q;
  logic [15:0] divisor_q;
  logic [7:0] irq_enable_q;
  logic [7:0] modem_ctl_q;
  logic [7:0] scratch_q;
  logic [7:0] ext_one_q;
  logic [7:0] ext_two_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Accesses only count while the clock enable is high
  assign wr_en = CE && WR_STB;
  assign rd_en = CE && RD_STB;

  // Decode of a byte written to the select offset
  always_comb
  begin
    bank_d = BANK1;
    if (!WDATA[SEL_BIT])
      bank_d = BANK0;
    else if (!WDATA[SEL_SUB_BIT])
      bank_d = BANK1;
    else if (WDATA[1] || WDATA[0])
      bank_d = BANK1;
    else if (WDATA == SEL_BANK2)
      bank_d = BANK2;
    else if (WDATA == SEL_BANK3)
      bank_d = BANK3;
    else if (WDATA == SEL_BANK4)
      bank_d = BANK4;
    else if (WDATA == SEL_BANK5)
      bank_d = BANK5;
    else if (WDATA == SEL_BANK6)
      bank_d = BANK6;
    else if (WDATA == SEL_BANK7)
      bank_d = BANK7;
  end

  // Select byte is decoded in every bank; line control takes it only with the top bit clear
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sel_q <= RST_BYTE;
      line_control_q <= RST_BYTE;
      bank_q <= BANK0;
    end
    else if (wr_en && ADDR == OFF_SEL)
    begin
      sel_q <= WDATA;
      bank_q <= bank_d;
      if (!WDATA[SEL_BIT])
        line_control_q <= WDATA;
    end
  end

  // Transmit data register and its load pulse
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_data_q <= RST_BYTE;
      tx_load_q <= 1'b0;
    end
    else if (CE)
    begin
      tx_load_q <= 1'b0;
      if (wr_en && bank_q == BANK0 && ADDR == OFF_DATA)
      begin
        tx_data_q <= WDATA;
        tx_load_q <= 1'b1;
      end
    end
  end

  // Write-only FIFO control, kept for the read-back copy
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      fifo_control_q <= RST_BYTE;
    else if (wr_en && bank_q == BANK0 && ADDR == OFF_EVT)
      fifo_control_q <= WDATA;
  end

  // One divisor, reached through the legacy and the extended bank
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      divisor_q <= RST_DIV;
    else if (wr_en && (bank_q == BANK1 || bank_q == BANK2))
    begin
      if (ADDR == OFF_DIV_LO)
        divisor_q[7:0] <= WDATA;
      else if (ADDR == OFF_DIV_HI)
        divisor_q[15:8] <= WDATA;
    end
  end

  // Plain read/write bytes of bank 0
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_enable_q <= RST_BYTE;
      modem_ctl_q <= RST_BYTE;
      scratch_q <= RST_BYTE;
    end
    else if (wr_en && bank_q == BANK0)
    begin
      if (ADDR == OFF_IRQ_EN)
        irq_enable_q <= WDATA;
      if (ADDR == OFF_MODEM_CTL)
        modem_ctl_q <= WDATA;
      if (ADDR == OFF_SCRATCH)
        scratch_q <= WDATA;
    end
  end

  // Extended control bytes of bank 2
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ext_one_q <= RST_BYTE;
      ext_two_q <= RST_BYTE;
    end
    else if (wr_en && bank_q == BANK2)
    begin
      if (ADDR == OFF_EXT_ONE)
        ext_one_q <= WDATA;
      if (ADDR == OFF_EXT_TWO)
        ext_two_q <= WDATA;
    end
  end

  // Read mux: the same offset means a different byte per bank
  always_comb
  begin
    rdata_d = RST_BYTE;
    if (ADDR == OFF_SEL)
      rdata_d = sel_q;
    else
    begin
      unique case (bank_q)
        BANK0:
        begin
          unique case (ADDR)
            OFF_DATA: rdata_d = STAT.rx_data;
            OFF_IRQ_EN: rdata_d = irq_enable_q;
            OFF_EVT: rdata_d = STAT.event_ident;
            OFF_MODEM_CTL: rdata_d = modem_ctl_q;
            OFF_LINK_STAT: rdata_d = STAT.link_status;
            OFF_MODEM_STAT: rdata_d = STAT.modem_status;
            OFF_SCRATCH: rdata_d = scratch_q;
            default: rdata_d = RST_BYTE;
          endcase
        end
        BANK1:
        begin
          if (ADDR == OFF_DIV_LO)
            rdata_d = divisor_q[7:0];
          else if (ADDR == OFF_DIV_HI)
            rdata_d = divisor_q[15:8];
        end
        BANK2:
        begin
          unique case (ADDR)
            OFF_DIV_LO: rdata_d = divisor_q[7:0];
            OFF_DIV_HI: rdata_d = divisor_q[15:8];
            OFF_EXT_ONE: rdata_d = ext_one_q;
            OFF_EXT_TWO: rdata_d = ext_two_q;
            OFF_TX_LVL: rdata_d = STAT.tx_level;
            OFF_RX_LVL: rdata_d = STAT.rx_level;
            default: rdata_d = RST_BYTE;
          endcase
        end
        BANK3:
        begin
          if (ADDR == OFF_REV)
            rdata_d = REVISION;
          else if (ADDR == OFF_LC_COPY)
            rdata_d = line_control_q;
          else if (ADDR == OFF_FC_COPY)
            rdata_d = fifo_control_q;
        end
        default: rdata_d = RST_BYTE; // Infrared banks live elsewhere
      endcase
    end
  end

  // Read data stands after the strobe until the next edge with the clock enable high
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      rdata_q <= RST_BYTE;
    else if (CE)
      rdata_q <= rd_en ? rdata_d : RST_BYTE;
  end

  // Read side effects toward the datapath
  assign RX_POP = rd_en && bank_q == BANK0 && ADDR == OFF_DATA;
  assign EVT_READ = rd_en && bank_q == BANK0 && ADDR == OFF_EVT;
  assign LINK_READ = rd_en && bank_q == BANK0 && ADDR == OFF_LINK_STAT;

  // Operating mode from the extended flag and the FIFO enable
  always_comb
  begin
    if (ext_one_q[EXT_MODE_BIT])
      MODE = MODE_EXT;
    else if (fifo_control_q[FIFO_EN_BIT])
      MODE = MODE_FIFO;
    else
      MODE = MODE_PLAIN;
  end

  // Outputs
  assign RDATA = rdata_q;
  assign TX_DATA = tx_data_q;
  assign TX_LOAD = tx_load_q;
  assign BANK = bank_q;
  assign CTRL.irq_enable = irq_enable_q;
  assign CTRL.line_control = line_control_q;
  assign CTRL.modem_ctl = modem_ctl_q;
  assign CTRL.fifo_control = fifo_control_q;
  assign CTRL.divisor = divisor_q;
  assign CTRL.ext_one = ext_one_q;
  assign CTRL.ext_two = ext_two_q;
  assign CTRL.scratch = scratch_q;

  // Checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  sequence s_wr(logic [2:0] off);
    wr_en && ADDR == off;
  endsequence

  sequence s_rd(logic [2:0] off);
    rd_en && ADDR == off;
  endsequence

  a_mode_ext_set: assert property (
    bank_q == BANK2 ##0 s_wr(OFF_EXT_ONE) ##0 WDATA[EXT_MODE_BIT]
    |=> MODE == MODE_EXT)
    else $error("extended mode not entered");

  a_bank_plain: assert property (
    s_wr(OFF_SEL) ##0 !WDATA[SEL_BIT]
    |=> bank_q == BANK0 && line_control_q == $past(WDATA))
    else $error("plain select write mishandled");

  a_line_keep: assert property (
    s_wr(OFF_SEL) ##0 WDATA[SEL_BIT]
    |=> line_control_q == $past(line_control_q))
    else $error("bank select altered line control");

  a_bank_legacy: assert property (
    s_wr(OFF_SEL) ##0 WDATA[7:6] == 2'b10 |=> bank_q == BANK1)
    else $error("legacy bank not selected");

  a_bank_ext: assert property (
    s_wr(OFF_SEL) ##0 (WDATA == SEL_BANK2 || WDATA == SEL_BANK3)
    |=> bank_q == (($past(WDATA) == SEL_BANK2) ? BANK2 : BANK3))
    else $error("extended bank not selected");

  a_sel_visible: assert property (
    s_rd(OFF_SEL) |=> RDATA == $past(sel_q))
    else $error("select byte not visible");

  a_tx_path: assert property (
    bank_q == BANK0 ##0 s_wr(OFF_DATA)
    |=> TX_LOAD && TX_DATA == $past(WDATA))
    else $error("transmit byte not loaded");

  a_rx_path: assert property (
    bank_q == BANK0 ##0 s_rd(OFF_DATA)
    |-> RX_POP ##1 RDATA == $past(STAT.rx_data))
    else $error("receive byte not returned");

  a_evt_fifo: assert property (
    bank_q == BANK0 ##0 s_wr(OFF_EVT)
    |=> CTRL.fifo_control == $past(WDATA) && !TX_LOAD)
    else $error("FIFO control write lost");

  a_legacy_div: assert property (
    bank_q == BANK1 ##0 s_wr(OFF_DIV_LO)
    |=> divisor_q[7:0] == $past(WDATA))
    else $error("legacy divisor not written");

  a_resv_zero: assert property (
    rd_en && bank_q == BANK1 && ADDR != OFF_SEL && ADDR > OFF_DIV_HI
    |=> RDATA == RST_BYTE)
    else $error("reserved byte not zero");

  a_fill_level: assert property (
    bank_q == BANK2 ##0 s_rd(OFF_TX_LVL)
    |=> RDATA == $past(STAT.tx_level))
    else $error("fill level not returned");

  a_line_copy: assert property (
    bank_q == BANK3 ##0 s_rd(OFF_LC_COPY)
    |=> RDATA == $past(line_control_q))
    else $error("line control copy wrong");

  a_fifo_copy: assert property (
    bank_q == BANK3 ##0 s_rd(OFF_FC_COPY)
    |=> RDATA == $past(fifo_control_q))
    else $error("FIFO control copy wrong");

  a_rev_read: assert property (
    bank_q == BANK3 ##0 s_rd(OFF_REV) |=> RDATA == REVISION)
    else $error("revision byte wrong");

  a_idle_read: assert property (
    CE && !RD_STB |=> RDATA == RST_BYTE)
    else $error("read data outside read slot");

  a_evt_pulse: assert property (
    bank_q == BANK0 ##0 s_rd(OFF_EVT)
    |-> EVT_READ && !RX_POP && !LINK_READ)
    else $error("event read pulse missing");

  a_pulse_idle: assert property (
    !rd_en |-> !RX_POP && !EVT_READ && !LINK_READ)
    else $error("read pulse without a read");

  a_bank_freeze: assert property (
    !CE |=> bank_q == $past(bank_q) && RDATA == $past(RDATA))
    else $error("state moved with clock enable low");

endmodule

`default_nettype wire

// [tb/ubr_datapath_model.sv]
`timescale 1ns/10ps
`default_nettype none

module ubr_datapath_model
  import ubr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_pop,
  output ubr_stat_s stat
);
  logic [7:0] rx_q;

  // Receive byte steps on every pop, so a lost pop shows up as a repeat
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_q <= 8'h30;
    else if (rx_pop)
      rx_q <= rx_q + 8'h01;
  end

  // Fixed status bytes, all distinct so a wrong routing is visible
  assign stat = '{rx_data: rx_q, event_ident: 8'hC1, link_status: 8'h60,
    modem_status: 8'hB0, tx_level: 8'h11, rx_level: 8'h13};
endmodule
`default_nettype wire

// [tb/test_ubr_regmap.sv]
`timescale 1ns/10ps
`default_nettype none

module test_ubr_regmap;
  import ubr_pkg::*;
  localparam logic [7:0] REV_ID = 8'h5A; // Arbitrary value
  logic clk, rst_n, ce, wr_stb, rd_stb;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, tx_data;
  logic tx_load, rx_pop, evt_read, link_read;
  ubr_stat_s stat;
  ubr_ctrl_s ctrl;
  ubr_bank_e bank;
  ubr_mode_e mode;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_evt = 0;
  int n_link = 0;
  logic [7:0] sel [12] = '{8'h7F, 8'h80, 8'hBF, 8'hC2, 8'hC1, 8'hC0,
    8'hE0, 8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4};
  logic [2:0] bnk [12] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
    3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};

  ubr_regmap #(.REVISION(REV_ID)) dut (.CLK_SYS(clk), .RST_N(rst_n),
    .CE(ce), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RDATA(rdata), .STAT(stat), .CTRL(ctrl), .TX_DATA(tx_data),
    .TX_LOAD(tx_load), .RX_POP(rx_pop), .EVT_READ(evt_read),
    .LINK_READ(link_read), .BANK(bank), .MODE(mode));

  ubr_datapath_model far (.clk(clk), .rst_n(rst_n), .rx_pop(rx_pop),
    .stat(stat));

  // Count read side-effect pulses at the edge that takes the strobe
  always @(posedge clk)
  begin
    if (evt_read)
      n_evt <= n_evt + 1;
    if (link_read)
      n_link <= n_link + 1;
  end

  // Free running system clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; the strobes stay put until the next call
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    wr_stb <= w;
    rd_stb <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rdata, e);
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog against a hung run
  initial
  begin
    #20000;
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(bank, BANK0);
    chk(mode, MODE_PLAIN);
    chk(ctrl, 80'h0);
    rd(3'h1, 8'h00);
    rd(3'h3, 8'h00);
    // Twelve select codes covering banks 0-7, decoded and read back through offset three
    for (int i = 0; i < 12; i++)
    begin
      wr(3'h3, sel[i]);
      chk(bank, bnk[i]);
      rd(3'h3, sel[i]);
    end
    // Bank 0 from bank 7: plain line control byte
    wr(3'h3, 8'h1B);
    chk(bank, BANK0);
    chk(ctrl.line_control, 8'h1B);
    wr(3'h1, 8'h0F);
    rd(3'h1, 8'h0F);
    wr(3'h7, 8'hA5);
    rd(3'h7, 8'hA5);
    wr(3'h4, 8'h3C);
    rd(3'h4, 8'h3C);
    chk(ctrl.modem_ctl, 8'h3C);
    chk(ctrl.irq_enable, 8'h0F);
    chk(ctrl.scratch, 8'hA5);
    wr(3'h2, 8'h41);
    chk(ctrl.fifo_control, 8'h41);
    chk(mode, MODE_FIFO);
    rd(3'h2, 8'hC1);
    rd(3'h5, 8'h60);
    rd(3'h6, 8'hB0);
    wr(3'h0, 8'h5C);
    chk(tx_load, 1'b1);
    chk(tx_data, 8'h5C);
    rd(3'h0, 8'h30);
    chk(tx_load, 1'b0);
    rd(3'h0, 8'h31);
    // Bank 1: legacy divisor and reserved places
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    chk(ctrl.divisor, 16'h1234);
    rd(3'h0, 8'h34);
    rd(3'h1, 8'h12);
    rd(3'h2, 8'h00);
    wr(3'h4, 8'hFF);
    rd(3'h4, 8'h00);
    rd(3'h7, 8'h00);
    // Bank 2: divisor, extended controls, fill levels
    wr(3'h3, 8'hE0);
    rd(3'h0, 8'h34);
    wr(3'h1, 8'h56);
    chk(ctrl.divisor, 16'h5634);
    wr(3'h2, 8'h01);
    chk(mode, MODE_EXT);
    rd(3'h2, 8'h01);
    wr(3'h4, 8'h22);
    rd(3'h4, 8'h22);
    chk(ctrl.ext_two, 8'h22);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h11);
    rd(3'h7, 8'h13);
    rd(3'h5, 8'h00);
    // Bank 3: read-only copies and revision
    wr(3'h3, 8'hE4);
    rd(3'h0, REV_ID);
    rd(3'h1, 8'h1B);
    rd(3'h2, 8'h41);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'h1B);
    rd(3'h5, 8'h00);
    // Infrared bank holds nothing but the select byte
    wr(3'h3, 8'hE8);
    rd(3'h1, 8'h00);
    rd(3'h3, 8'hE8);
    // Clock enable low: write is dropped
    ce <= 1'b0;
    wr(3'h3, 8'h00);
    chk(bank, BANK4);
    chk(rdata, 8'hE8);
    ce <= 1'b1;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    @(posedge clk);
    #1;
    chk(rdata, 8'h00);
    chk(n_evt, 1);
    chk(n_link, 1);
    end_of_test();
  end
endmodule
`default_nettype wire
